// ==== rtl/asp_pkg.sv ====
// Constants, types and functional notes for the async serial port core
// Functional notes
// - Line rates up to 625 kbps are supported.
// - Character length bit: 0 gives 7 data bits, 1 gives 8, both directions.
// - Data bits always travel least significant bit first.
// - Transmit and receive run independently and at the same time.
// - A completed received character moves into the receive buffer unless the buffer value is still unread.
// - In 7-bit mode buffer bits 0 to 6 hold data, bit 7 reads 0.
// - On overrun the new character is dropped; the unread buffer value stays.
// - Receive buffer is read-only, 8 bits, all ones at reset or power off.
// - Writing the transmit register starts sending; it cannot be read back.
// - Transmit register is all ones at reset, power off or transmit disabled.
// - Power off holds the core in asynchronous reset; receive input reads high.
// - Enables, synchronised to the base clock, synchronously reset their paths.
// - Parity field: none, send zero and skip check, odd, even.
// - Transmitter sends 1 or 2 stop bits; receiver always expects one.
// - Enabling reception with the line low starts a reception at once.
// - Mode register bit 0 resets to 1 and is always written as 1.
// - With the clock stopped all state, including the output pin, holds.
// - Framing error when the first stop bit position is not high.
// - Bit rate is the baud counter output clock divided by two.
package asp_pkg;
	localparam logic [15:0] MODE_ADDR = 16'hff70;
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] RXB_RST = 8'hff;
	localparam logic [7:0] TXS_RST = 8'hff;
	localparam int POWER_BIT = 7;
	localparam int TXEN_BIT = 6;
	localparam int RXEN_BIT = 5;
	localparam int PAR_HI_BIT = 4;
	localparam int PAR_LO_BIT = 3;
	localparam int CLEN_BIT = 2;
	localparam int STOP_BIT = 1;
	localparam int FIXED_BIT = 0;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ZERO = 2'h1;
	localparam logic [1:0] PAR_ODD = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	localparam int LINE_MAX_KBPS = 625;
	localparam int CLK_PERIOD_NS = 10;
	// Shortest bit in cycles; ticks must not come faster than half of it
	localparam int MIN_BIT_CYC = 1000000 / (LINE_MAX_KBPS * CLK_PERIOD_NS);
	localparam logic [2:0] LAST7 = 3'h6;
	localparam logic [2:0] LAST8 = 3'h7;

	typedef enum logic [4:0] {
		TX_IDLE = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} asp_tx_e;

	typedef enum logic [4:0] {
		RX_IDLE = 5'h01,
		RX_START = 5'h02,
		RX_DATA = 5'h04,
		RX_PAR = 5'h08,
		RX_STOP = 5'h10
	} asp_rx_e;

	// Parity bit that makes the frame match the selected mode
	function automatic logic asp_par_bit(input logic [7:0] d, input logic [1:0] mode);
		logic ones;
		ones = ^d;
		unique case (mode)
			PAR_ODD: asp_par_bit = ~ones;
			PAR_EVEN: asp_par_bit = ones;
			default: asp_par_bit = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] asp_last_bit(input logic char8);
		asp_last_bit = char8 ? LAST8 : LAST7;
	endfunction
endpackage

// ==== rtl/asp_tx.sv ====
// Transmit sequencer for the async serial port core
`timescale 1ns/1ps
module asp_tx (
	input wire logic clk_i,
	input wire logic core_rst_b_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic char8_i,
	input wire logic [1:0] par_mode_i,
	input wire logic stop2_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic line_o,
	output logic done_o
);
	import asp_pkg::*;
	asp_tx_e state_ff, nxt_state;
	logic [7:0] txs_ff, nxt_txs;
	logic go_ff, nxt_go, half_ff, nxt_half, stop2nd_ff, nxt_stop2nd;
	logic line_ff, nxt_line, done_ff, nxt_done;
	logic [2:0] cnt_ff, nxt_cnt;
	logic [7:0] masked;

	always_comb begin
		masked = char8_i ? txs_ff : {1'b0, txs_ff[6:0]};
		nxt_state = state_ff;
		nxt_txs = txs_ff;
		nxt_go = go_ff;
		nxt_half = half_ff;
		nxt_stop2nd = stop2nd_ff;
		nxt_line = line_ff;
		nxt_cnt = cnt_ff;
		nxt_done = 1'b0;
		if (!en_i) begin
			nxt_state = TX_IDLE;
			nxt_txs = TXS_RST;
			nxt_go = 1'b0;
			nxt_half = 1'b0;
			nxt_line = 1'b1;
		end else begin
			if (wr_i) begin
				nxt_txs = wdata_i;
				nxt_go = 1'b1;
			end
			if (tick_i) begin
				nxt_half = ~half_ff;
				unique case (state_ff)
					TX_IDLE: begin
						nxt_half = 1'b0;
						nxt_line = 1'b1;
						if (go_ff) begin
							nxt_state = TX_START;
							nxt_go = wr_i;
							nxt_line = 1'b0;
						end
					end
					TX_START: if (half_ff) begin
						nxt_state = TX_DATA;
						nxt_cnt = 3'h0;
						nxt_line = txs_ff[0];
					end
					TX_DATA: if (half_ff) begin
						if (cnt_ff == asp_last_bit(char8_i)) begin
							nxt_stop2nd = 1'b0;
							if (par_mode_i == PAR_NONE) begin
								nxt_state = TX_STOP;
								nxt_line = 1'b1;
							end else begin
								nxt_state = TX_PAR;
								nxt_line = asp_par_bit(masked, par_mode_i);
							end
						end else begin
							nxt_cnt = cnt_ff + 3'h1;
							nxt_line = txs_ff[cnt_ff + 3'h1];
						end
					end
					TX_PAR: if (half_ff) begin
						nxt_state = TX_STOP;
						nxt_line = 1'b1;
					end
					TX_STOP: if (half_ff) begin
						if (stop2_i && !stop2nd_ff) begin
							nxt_stop2nd = 1'b1;
						end else begin
							nxt_state = TX_IDLE;
							nxt_done = 1'b1;
						end
					end
				endcase
			end
		end
	end

	// Registers simply hold when the clock stops, pin included
	always_ff @(posedge clk_i or negedge core_rst_b_i) begin
		if (!core_rst_b_i) begin
			state_ff <= TX_IDLE;
			txs_ff <= TXS_RST;
			go_ff <= 1'b0;
			half_ff <= 1'b0;
			stop2nd_ff <= 1'b0;
			line_ff <= 1'b1;
			cnt_ff <= 3'h0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			txs_ff <= nxt_txs;
			go_ff <= nxt_go;
			half_ff <= nxt_half;
			stop2nd_ff <= nxt_stop2nd;
			line_ff <= nxt_line;
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign line_o = line_ff;
	assign done_o = done_ff;
endmodule

// ==== rtl/asp_rx.sv ====
// Receive sequencer for the async serial port core
`timescale 1ns/1ps
module asp_rx (
	input wire logic clk_i,
	input wire logic core_rst_b_i,
	input wire logic en_i,
	input wire logic tick_i,
	input wire logic line_i,
	input wire logic char8_i,
	input wire logic [1:0] par_mode_i,
	output logic [7:0] data_o,
	output logic done_o,
	output logic perr_o,
	output logic ferr_o
);
	import asp_pkg::*;
	asp_rx_e state_ff, nxt_state;
	logic [7:0] data_ff, nxt_data;
	logic [2:0] cnt_ff, nxt_cnt;
	logic half_ff, nxt_half, pbit_ff, nxt_pbit;
	logic done_ff, nxt_done, perr_ff, nxt_perr, ferr_ff, nxt_ferr;

	always_comb begin
		nxt_state = state_ff;
		nxt_data = data_ff;
		nxt_cnt = cnt_ff;
		nxt_half = half_ff;
		nxt_pbit = pbit_ff;
		nxt_done = 1'b0;
		nxt_perr = 1'b0;
		nxt_ferr = 1'b0;
		if (!en_i) begin
			nxt_state = RX_IDLE;
			nxt_half = 1'b0;
		end else if (tick_i) begin
			nxt_half = ~half_ff;
			unique case (state_ff)
				RX_IDLE: begin
					nxt_half = 1'b0;
					// A line already low at enable starts a frame
					if (!line_i) begin
						nxt_state = RX_START;
					end
				end
				RX_START: begin
					nxt_half = 1'b0;
					nxt_cnt = 3'h0;
					nxt_data = 8'h00;
					nxt_state = line_i ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (half_ff) begin
					nxt_data[cnt_ff] = line_i;
					if (cnt_ff == asp_last_bit(char8_i)) begin
						nxt_state = (par_mode_i == PAR_NONE) ? RX_STOP : RX_PAR;
					end else begin
						nxt_cnt = cnt_ff + 3'h1;
					end
				end
				RX_PAR: if (half_ff) begin
					nxt_pbit = line_i;
					nxt_state = RX_STOP;
				end
				RX_STOP: if (half_ff) begin
					nxt_state = RX_IDLE;
					nxt_done = 1'b1;
					nxt_ferr = !line_i;
					nxt_perr = par_mode_i[1] &&
						(pbit_ff != asp_par_bit(data_ff, par_mode_i));
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge core_rst_b_i) begin
		if (!core_rst_b_i) begin
			state_ff <= RX_IDLE;
			data_ff <= 8'h00;
			cnt_ff <= 3'h0;
			half_ff <= 1'b0;
			pbit_ff <= 1'b0;
			done_ff <= 1'b0;
			perr_ff <= 1'b0;
			ferr_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			data_ff <= nxt_data;
			cnt_ff <= nxt_cnt;
			half_ff <= nxt_half;
			pbit_ff <= nxt_pbit;
			done_ff <= nxt_done;
			perr_ff <= nxt_perr;
			ferr_ff <= nxt_ferr;
		end
	end

	assign data_o = data_ff;
	assign done_o = done_ff;
	assign perr_o = perr_ff;
	assign ferr_o = ferr_ff;
endmodule

// ==== rtl/asp_core.sv ====
// Top of the async serial port core: mode register, buffers, enables
`timescale 1ns/1ps
module asp_core (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic brg_tick_i,
	input wire logic mode_wr_i,
	input wire logic [7:0] mode_wdata_i,
	output logic [7:0] mode_o,
	input wire logic tx_wr_i,
	input wire logic [7:0] tx_wdata_i,
	input wire logic rxb_rd_i,
	output logic [7:0] rxb_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o,
	output logic tx_done_irq_o,
	output logic rx_done_o,
	output logic overrun_flag_o,
	output logic parity_error_flag_o,
	output logic framing_error_o
);
	import asp_pkg::*;

	logic rst_s1_ff, rst_s2_ff;
	logic core_rst_b;
	logic [7:0] mode_ff, nxt_mode;
	logic power_en, char8, stop2;
	logic [1:0] par_mode;
	logic txen_sync_ff, nxt_txen_sync, rxen_sync_ff, nxt_rxen_sync;
	logic pin_s1_ff, pin_s2_ff;
	logic [7:0] rxb_ff, nxt_rxb;
	logic unread_ff, nxt_unread;
	logic ovr_ff, nxt_ovr, perr_ff, nxt_perr, ferr_ff, nxt_ferr, rdone_ff, nxt_rdone;
	logic [7:0] rx_data;
	logic rx_done, rx_perr, rx_ferr;
	logic tx_line, tx_done;

	// Reset release through two stages
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// Mode register
	always_comb begin
		nxt_mode = mode_ff;
		if (mode_wr_i) begin
			nxt_mode = mode_wdata_i;
		end
		nxt_mode[FIXED_BIT] = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_s2_ff) begin
		if (!rst_s2_ff) begin
			mode_ff <= MODE_RST;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	assign power_en = mode_ff[POWER_BIT];
	assign par_mode = {mode_ff[PAR_HI_BIT], mode_ff[PAR_LO_BIT]};
	assign char8 = mode_ff[CLEN_BIT];
	assign stop2 = mode_ff[STOP_BIT];
	// Power off gates the core into reset; glitch-free since both are flops
	assign core_rst_b = rst_s2_ff & power_en;

	// Enables follow the mode bits only on base clock ticks
	always_comb begin
		nxt_txen_sync = txen_sync_ff;
		nxt_rxen_sync = rxen_sync_ff;
		if (brg_tick_i) begin
			nxt_txen_sync = mode_ff[TXEN_BIT];
			nxt_rxen_sync = mode_ff[RXEN_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge core_rst_b) begin
		if (!core_rst_b) begin
			txen_sync_ff <= 1'b0;
			rxen_sync_ff <= 1'b0;
		end else begin
			txen_sync_ff <= nxt_txen_sync;
			rxen_sync_ff <= nxt_rxen_sync;
		end
	end

	// Pin synchroniser; reads high while powered off
	always_ff @(posedge clk_i or negedge core_rst_b) begin
		if (!core_rst_b) begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= serial_in_pin_i;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// The two paths share only the mode bits and the tick
	asp_tx u_tx (
		.clk_i(clk_i),
		.core_rst_b_i(core_rst_b),
		.en_i(txen_sync_ff),
		.tick_i(brg_tick_i),
		.char8_i(char8),
		.par_mode_i(par_mode),
		.stop2_i(stop2),
		.wr_i(tx_wr_i),
		.wdata_i(tx_wdata_i),
		.line_o(tx_line),
		.done_o(tx_done)
	);

	asp_rx u_rx (
		.clk_i(clk_i),
		.core_rst_b_i(core_rst_b),
		.en_i(rxen_sync_ff),
		.tick_i(brg_tick_i),
		.line_i(pin_s2_ff),
		.char8_i(char8),
		.par_mode_i(par_mode),
		.data_o(rx_data),
		.done_o(rx_done),
		.perr_o(rx_perr),
		.ferr_o(rx_ferr)
	);

	// Receive buffer and overrun tracking
	always_comb begin
		nxt_rxb = rxb_ff;
		nxt_unread = unread_ff;
		nxt_ovr = 1'b0;
		nxt_perr = 1'b0;
		nxt_ferr = 1'b0;
		nxt_rdone = 1'b0;
		if (rxb_rd_i) begin
			nxt_unread = 1'b0;
		end
		if (rx_done) begin
			nxt_rdone = 1'b1;
			nxt_perr = rx_perr;
			nxt_ferr = rx_ferr;
			if (unread_ff && !rxb_rd_i) begin
				nxt_ovr = 1'b1;
			end else begin
				nxt_rxb = rx_data;
				nxt_unread = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge core_rst_b) begin
		if (!core_rst_b) begin
			rxb_ff <= RXB_RST;
			unread_ff <= 1'b0;
			ovr_ff <= 1'b0;
			perr_ff <= 1'b0;
			ferr_ff <= 1'b0;
			rdone_ff <= 1'b0;
		end else begin
			rxb_ff <= nxt_rxb;
			unread_ff <= nxt_unread;
			ovr_ff <= nxt_ovr;
			perr_ff <= nxt_perr;
			ferr_ff <= nxt_ferr;
			rdone_ff <= nxt_rdone;
		end
	end

	assign mode_o = mode_ff;
	assign rxb_o = rxb_ff;
	assign serial_out_pin_o = tx_line;
	assign tx_done_irq_o = tx_done;
	assign rx_done_o = rdone_ff;
	assign overrun_flag_o = ovr_ff;
	assign parity_error_flag_o = perr_ff;
	assign framing_error_o = ferr_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!core_rst_b);

	sequence s_done_unread;
		rx_done && unread_ff && !rxb_rd_i;
	endsequence

	sequence s_done_free;
		rx_done && (!unread_ff || rxb_rd_i);
	endsequence

	rxb_hold_a: assert property (s_done_unread |=> overrun_flag_o && $stable(rxb_o))
		else $error("receive buffer changed on overrun");

	rxb_load_a: assert property (s_done_free |=> rxb_o == $past(rx_data) && !overrun_flag_o)
		else $error("completed character not moved to buffer");

	rxb_top_a: assert property ((s_done_free and !char8) |=> rxb_o[7] == 1'b0)
		else $error("7-bit character left buffer top bit set");

	mode_fixed_a: assert property (mode_o[FIXED_BIT] == 1'b1)
		else $error("mode bit 0 not one");

	tx_idle_a: assert property (!txen_sync_ff ##1 !txen_sync_ff |-> serial_out_pin_o)
		else $error("line not high while transmit disabled");

	zero_par_a: assert property (par_mode != PAR_ODD && par_mode != PAR_EVEN
		|-> ##1 !parity_error_flag_o)
		else $error("parity error without checking parity mode");

	en_tick_a: assert property ($changed(txen_sync_ff) || $changed(rxen_sync_ff)
		|-> $past(brg_tick_i))
		else $error("enable changed off a base clock tick");

	done_stop_a: assert property (tx_done_irq_o |-> serial_out_pin_o && $past(serial_out_pin_o))
		else $error("transmit done without stop level on line");

	ovr_cause_a: assert property (overrun_flag_o |-> $past(unread_ff) && $past(rx_done))
		else $error("overrun without unread buffer");
endmodule

// ==== sim/asp_line_peer.sv ====
// Remote serial transceiver model facing the core's line pins
`timescale 1ns/1ps
module asp_line_peer #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	logic [11:0] cap;
	int cap_len = 10;
	initial line_o = 1'b1;
	// Start low, bits LSB first, then idle high between frames
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			line_o = bits[i];
			repeat (BIT_CYC) @(negedge clk_i);
		end
		line_o = 1'b1;
	endtask
	// Mid-bit sampling, start bit kept at index 0
	always begin
		@(negedge line_i);
		repeat (BIT_CYC / 2) @(posedge clk_i);
		// No wait after the last sample, so a back-to-back start edge is not missed
		for (int i = 0; i < cap_len; i++) begin
			if (i > 0)
				repeat (BIT_CYC) @(posedge clk_i);
			cap[i] = line_i;
		end
	end
endmodule

// ==== sim/asp_core_tb.sv ====
// Self-checking bench for the async serial port core
`timescale 1ns/1ps
module asp_core_tb;
	import asp_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic tick = 1'b0;
	logic mwr = 1'b0;
	logic twr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] md = 8'h01;
	logic [7:0] td = 8'h00;
	logic [7:0] mode, rxb;
	logic rx_line, out_line, tx_done, rx_done, ovr, perr, ferr;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	int tc = 0;
	always #5 clk = ~clk;
	// Tick every 4 cycles, so one line bit is 8 cycles
	always @(negedge clk) begin
		tc <= (tc + 1) % 4;
		tick <= (tc == 3);
	end
	asp_core u_asp_core (.clk_i(clk), .rst_b_i(rst_b), .brg_tick_i(tick), .mode_wr_i(mwr),
		.mode_wdata_i(md), .mode_o(mode), .tx_wr_i(twr), .tx_wdata_i(td), .rxb_rd_i(rd),
		.rxb_o(rxb), .serial_in_pin_i(rx_line), .serial_out_pin_o(out_line),
		.tx_done_irq_o(tx_done), .rx_done_o(rx_done), .overrun_flag_o(ovr),
		.parity_error_flag_o(perr), .framing_error_o(ferr));
	asp_line_peer #(.BIT_CYC(8)) u_asp_line_peer (.clk_i(clk), .line_i(out_line),
		.line_o(rx_line));
	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Waits three ticks after the write, covering both enable settling gaps
	task automatic wr_mode(input logic [7:0] d);
		@(negedge clk);
		mwr = 1'b1;
		md = d;
		@(negedge clk);
		mwr = 1'b0;
		repeat (12) @(negedge clk);
		chk(mode === d, "mode readback");
	endtask
	task automatic wr_tx(input logic [7:0] d);
		@(negedge clk);
		twr = 1'b1;
		td = d;
		@(negedge clk);
		twr = 1'b0;
	endtask
	task automatic wait_pulse(input logic rx);
		int n;
		n = 0;
		while ((rx ? rx_done : tx_done) !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk((rx ? rx_done : tx_done) === 1'b1, "done pulse");
	endtask
	function automatic logic [11:0] frame_of(input logic [7:0] d, input logic c8,
		input logic [1:0] pm, input logic s2, output int n);
		logic [11:0] f;
		logic [7:0] dd;
		dd = c8 ? d : {1'b0, d[6:0]};
		f = 12'hfff;
		f[0] = 1'b0;
		n = c8 ? 9 : 8;
		for (int i = 0; i < n - 1; i++)
			f[i + 1] = dd[i];
		if (pm != PAR_NONE) begin
			f[n] = (pm == PAR_ODD) ? ~^dd : (pm == PAR_EVEN) ? ^dd : 1'b0;
			n++;
		end
		n = n + 1 + int'(s2);
		return f;
	endfunction
	task automatic test_reset();
		chk(mode === 8'h01, "mode reset");
		chk(rxb === 8'hff, "rx buffer reset");
		chk(out_line === 1'b1, "line idle");
		$display("test reset done");
	endtask
	task automatic test_tx();
		int n;
		logic [7:0] d;
		logic [11:0] f;
		for (int i = 0; i < 8; i++) begin
			wr_mode({3'b100, i[1:0], i[2], i[0] ^ i[1], 1'b1});
			wr_mode({3'b110, i[1:0], i[2], i[0] ^ i[1], 1'b1});
			for (int j = 0; j < 2; j++) begin
				d = (8'h96 + 8'(i * 37)) ^ 8'(j * 255);
				f = frame_of(d, i[2], i[1:0], i[0] ^ i[1], n);
				u_asp_line_peer.cap_len = n;
				wr_tx(d);
				wait_pulse(1'b0);
				chk(((u_asp_line_peer.cap ^ f) & ((12'h1 << n) - 12'h1)) === 12'h0,
					"tx frame");
				chk(out_line === 1'b1, "tx idle");
			end
		end
		$display("test tx done");
	endtask
	task automatic set_rx(input logic [1:0] pm, input logic c8);
		wr_mode({3'b100, pm, c8, 2'b01});
		wr_mode({3'b101, pm, c8, 2'b01});
	endtask
	task automatic rx_one(input logic [7:0] d, input logic c8, input logic [1:0] pm,
		input logic [11:0] flip, input logic [2:0] fl, input logic [7:0] ex, input logic rda);
		int n;
		logic [11:0] f;
		f = frame_of(d, c8, pm, 1'b0, n) ^ flip;
		fork
			u_asp_line_peer.send(f, n);
			begin
				wait_pulse(1'b1);
				chk({perr, ferr, ovr} === fl, "rx flags");
			end
		join
		chk(rxb === ex, "rx buffer");
		@(negedge clk);
		rd = rda;
		@(negedge clk);
		rd = 1'b0;
		repeat (16) @(negedge clk);
	endtask
	task automatic test_rx();
		set_rx(PAR_EVEN, 1'b1);
		rx_one(8'h3c, 1'b1, PAR_EVEN, 12'h0, 3'b000, 8'h3c, 1'b1);
		set_rx(PAR_NONE, 1'b0);
		rx_one(8'hd5, 1'b0, PAR_NONE, 12'h0, 3'b000, 8'h55, 1'b1);
		set_rx(PAR_ODD, 1'b1);
		rx_one(8'h81, 1'b1, PAR_ODD, 12'h200, 3'b100, 8'h81, 1'b1);
		set_rx(PAR_ZERO, 1'b1);
		rx_one(8'h42, 1'b1, PAR_ZERO, 12'h200, 3'b000, 8'h42, 1'b1);
		set_rx(PAR_NONE, 1'b1);
		rx_one(8'h18, 1'b1, PAR_NONE, 12'h200, 3'b010, 8'h18, 1'b1);
		rx_one(8'h5a, 1'b1, PAR_NONE, 12'h0, 3'b000, 8'h5a, 1'b0);
		rx_one(8'ha5, 1'b1, PAR_NONE, 12'h0, 3'b001, 8'h5a, 1'b1);
		$display("test rx done");
	endtask
	task automatic test_duplex();
		int n;
		logic [11:0] f;
		wr_mode(8'he5);
		u_asp_line_peer.cap_len = 10;
		f = frame_of(8'h6e, 1'b1, PAR_NONE, 1'b0, n);
		fork
			u_asp_line_peer.send(f, n);
			begin
				wr_tx(8'h91);
				wait_pulse(1'b0);
			end
			wait_pulse(1'b1);
		join
		chk(rxb === 8'h6e, "duplex rx");
		f = frame_of(8'h91, 1'b1, PAR_NONE, 1'b0, n);
		chk(u_asp_line_peer.cap[9:0] === f[9:0], "duplex tx");
		$display("test duplex done");
	endtask
	task automatic test_power();
		wr_tx(8'h00);
		repeat (24) @(negedge clk);
		chk(out_line === 1'b0, "tx running");
		wr_mode(8'h85);
		chk(out_line === 1'b1, "tx abort");
		wr_mode(8'h01);
		chk(rxb === 8'hff && out_line === 1'b1, "power off");
		wr_tx(8'h00);
		repeat (16) @(negedge clk);
		chk(out_line === 1'b1, "write ignored");
		$display("test power done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			$display("mismatch at %0t: timeout", $time);
			test_done();
		end
	end
	initial begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		test_reset();
		test_tx();
		test_rx();
		test_duplex();
		test_power();
		test_done();
	end
endmodule
